/* design/sbcx_defs.svh */
// constants for the stack, branch and control execution unit
`ifndef SBCX_DEFS_SVH
`define SBCX_DEFS_SVH

`define SBCX_PC_RST          16'h0000
`define SBCX_SP_RST          16'h0000
`define SBCX_STATE_RST       8'h00

`define SBCX_BIT_GATE        3'h7
`define SBCX_BIT_NULL        3'h6
`define SBCX_BIT_BANK_HIGH   3'h5
`define SBCX_BIT_BANK_LOW    3'h3
`define SBCX_BIT_CARRY       3'h0

`define SBCX_LEN_1           3'h1
`define SBCX_LEN_2           3'h2
`define SBCX_LEN_3           3'h3
`define SBCX_LEN_4           3'h4

`define SBCX_CYC_2           4'h2
`define SBCX_CYC_4           4'h4
`define SBCX_CYC_6           4'h6
`define SBCX_CYC_8           4'h8
`define SBCX_CYC_9           4'h9
`define SBCX_CYC_10          4'hA
`define SBCX_CYC_11          4'hB
`define SBCX_CYC_12          4'hC

`endif

/* design/sbcx_pkg.sv */
// types for the stack, branch and control execution unit
`default_nettype none
package sbcx_pkg;

    typedef enum logic [4:0] {
        OP_POP_STATE          = 5'h00,
        OP_POP_PAIR           = 5'h01,
        OP_XFER_SP_IMM        = 5'h02,
        OP_XFER_SP_ACCUM      = 5'h03,
        OP_XFER_ACCUM_SP      = 5'h04,
        OP_JUMP_ABS           = 5'h05,
        OP_JUMP_REL           = 5'h06,
        OP_JUMP_ACCUM         = 5'h07,
        OP_CARRY_BRANCH       = 5'h08,
        OP_NO_CARRY_BRANCH    = 5'h09,
        OP_NULL_BRANCH        = 5'h0A,
        OP_NONNULL_BRANCH     = 5'h0B,
        OP_BIT_TRUE_BRANCH    = 5'h0C,
        OP_BIT_FALSE_BRANCH   = 5'h0D,
        OP_BIT_CLEAR_BRANCH   = 5'h0E,
        OP_DEC_LOOP_B         = 5'h0F,
        OP_DEC_LOOP_C         = 5'h10,
        OP_DEC_LOOP_MEM       = 5'h11,
        OP_BANK_SEL           = 5'h12,
        OP_IDLE_INSTR         = 5'h13,
        OP_INT_UNMASK         = 5'h14,
        OP_INT_MASK           = 5'h15,
        OP_HALT               = 5'h16,
        OP_STOP               = 5'h17
    } sbcx_op_t;

    typedef enum logic [2:0] {
        BK_SADDR = 3'h0,
        BK_SFR   = 3'h1,
        BK_ACC   = 3'h2,
        BK_STATE = 3'h3,
        BK_HL    = 3'h4
    } sbcx_bit_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_HALT = 2'h2,
        ST_STOP = 2'h3
    } sbcx_state_t;

    typedef struct packed {
        sbcx_op_t       op;
        sbcx_bit_kind_t kind;
        logic           slow;
        logic [2:0]     bit_sel;
        logic [7:0]     bit_byte;
        logic [7:0]     opnd_lo;
        logic [7:0]     opnd_hi;
        logic [15:0]    imm16;
        logic [15:0]    accum_pair;
        logic [7:0]     b;
        logic [7:0]     c;
        logic [7:0]     rel_offset;
        logic [1:0]     bank;
    } sbcx_instr_t;

    typedef struct packed {
        logic [7:0]  b;
        logic        b_wr;
        logic [7:0]  c;
        logic        c_wr;
        logic [15:0] accum_pair;
        logic        accum_wr;
        logic [15:0] reg_pair;
        logic        pair_wr;
        logic [7:0]  mem_data;
        logic        mem_wr;
    } sbcx_wb_t;

endpackage : sbcx_pkg
`default_nettype wire

/* design/sbcx_core.sv */
// execution unit for stack, branch and cpu control instructions
// Operation
// - pop state word, sp plus one, flags restored
// - pop pair: high sp+1, low sp, 4 cycles
// - jump via accum pair, high from A, 8 cycles
// - carry branches add 2 plus offset, 6 cycles
// - no-carry branch taken only when carry clear
// - null branch taken when zero flag set
// - nonnull branch taken when zero flag clear
// - bit-true branch adds length 3 or 4
// - bit-false short form 4 bytes, 10/11 cycles
// - test-clear branch also clears the tested bit
// - register loop decrements, branches if nonzero
// - memory loop: 3 bytes, 8 or 10 cycles
// - interrupt unmask sets the gate flag, 6 cycles
// - interrupt mask clears the gate flag, 6 cycles
// - slow column when operand outside fast ram
// - each counted cycle is one cpu clock
`include "sbcx_defs.svh"
`default_nettype none
module sbcx_core (
    input  wire logic                  REF_CLK,
    input  wire logic                  NRST,
    input  wire logic [2:0]            CLK_SEL,
    input  wire logic                  START,
    input  wire sbcx_pkg::sbcx_instr_t INSTR,
    input  wire logic                  WAKE,
    output logic [15:0]                PC,
    output logic [15:0]                SP,
    output logic [7:0]                 PROGRAM_STATE_WORD,
    output var sbcx_pkg::sbcx_wb_t     WB,
    output logic                       DONE,
    output logic                       BUSY,
    output logic                       HALTED,
    output logic                       STOPPED
);
    import sbcx_pkg::*;

    sbcx_state_t state_reg;
    sbcx_instr_t cur_reg;
    sbcx_wb_t    wb_reg, wb_pend_reg, wb_next;
    logic [15:0] pc_reg, pc_pend_reg, pc_next;
    logic [15:0] sp_reg, sp_pend_reg, sp_next;
    logic [7:0]  word_reg, word_pend_reg, word_next;
    logic        halt_pend_reg, halt_next, stop_pend_reg, stop_next;
    logic [3:0]  cnt_reg, need_reg;
    logic [6:0]  div_cnt_reg;
    logic [6:0]  div_mask;
    logic        cpu_en_reg;
    logic        done_reg, busy_reg, halted_reg, stopped_reg;
    logic        commit;
    logic [15:0] rel_pc;
    logic [7:0]  bit_src, bit_mask, dec_val;
    logic        bit_hit;

    // instruction length in bytes
    function automatic logic [2:0] len_of(input sbcx_instr_t i);
        logic [2:0] r;
        r = `SBCX_LEN_2;
        unique case (i.op)
            OP_POP_STATE, OP_POP_PAIR, OP_IDLE_INSTR: r = `SBCX_LEN_1;
            OP_XFER_SP_IMM:                          r = `SBCX_LEN_4;
            OP_JUMP_ABS, OP_DEC_LOOP_MEM:            r = `SBCX_LEN_3;
            OP_BIT_TRUE_BRANCH:
                r = (i.kind == BK_SFR) ? `SBCX_LEN_4 : `SBCX_LEN_3;
            OP_BIT_FALSE_BRANCH, OP_BIT_CLEAR_BRANCH:
                r = (i.kind == BK_ACC || i.kind == BK_HL) ?
                    `SBCX_LEN_3 : `SBCX_LEN_4;
            default: r = `SBCX_LEN_2;
        endcase
        return r;
    endfunction : len_of

    // cycle count; slow picks the second column where one exists
    function automatic logic [3:0] cyc_of(input sbcx_instr_t i);
        logic [3:0] r;
        logic       t;
        logic       f;
        r = `SBCX_CYC_6;
        t = (i.op == OP_BIT_TRUE_BRANCH);
        f = (i.op == OP_BIT_FALSE_BRANCH);
        unique case (i.op)
            OP_POP_STATE, OP_IDLE_INSTR:   r = `SBCX_CYC_2;
            OP_POP_PAIR, OP_BANK_SEL:      r = `SBCX_CYC_4;
            OP_XFER_SP_IMM:                r = `SBCX_CYC_10;
            OP_XFER_SP_ACCUM, OP_XFER_ACCUM_SP,
            OP_JUMP_ACCUM:                 r = `SBCX_CYC_8;
            OP_DEC_LOOP_MEM:
                r = i.slow ? `SBCX_CYC_10 : `SBCX_CYC_8;
            OP_BIT_TRUE_BRANCH, OP_BIT_FALSE_BRANCH, OP_BIT_CLEAR_BRANCH: begin
                case (i.kind)
                    BK_SADDR: r = !i.slow ? (t ? `SBCX_CYC_8 : `SBCX_CYC_10)
                                  : (t ? `SBCX_CYC_9 : f ? `SBCX_CYC_11
                                  : `SBCX_CYC_12);
                    BK_HL:    r = !i.slow ? `SBCX_CYC_10
                                  : ((t || f) ? `SBCX_CYC_11
                                  : `SBCX_CYC_12);
                    BK_SFR:   r = (t || f) ? `SBCX_CYC_11 : `SBCX_CYC_12;
                    BK_STATE: r = t ? `SBCX_CYC_9
                                  : (f ? `SBCX_CYC_11 : `SBCX_CYC_12);
                    default:  r = `SBCX_CYC_8;
                endcase
            end
            default: r = `SBCX_CYC_6;
        endcase
        return r;
    endfunction : cyc_of

    // pc plus length plus signed offset
    function automatic logic [15:0] rel_tgt(input logic [15:0] pc,
                                            input logic [2:0]  len,
                                            input logic [7:0]  off);
        return pc + {13'h0000, len} + {{8{off[7]}}, off};
    endfunction : rel_tgt

    // cpu clock enable from the selected divide ratio
    assign div_mask = 7'((8'h01 << CLK_SEL) - 8'h01);

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            div_cnt_reg <= 7'h00;
            cpu_en_reg  <= 1'b0;
        end else if (state_reg == ST_STOP) begin
            // stop freezes the cpu clock, unlike halt
            cpu_en_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
            cpu_en_reg  <= ((div_cnt_reg & div_mask) == 7'h00);
        end
    end

    // evaluate the incoming instruction against committed state
    always_comb begin
        rel_pc    = rel_tgt(pc_reg, len_of(INSTR), INSTR.rel_offset);
        pc_next   = pc_reg + {13'h0000, len_of(INSTR)};
        sp_next   = sp_reg;
        word_next = word_reg;
        wb_next   = '0;
        halt_next = 1'b0;
        stop_next = 1'b0;
        bit_src   = (INSTR.kind == BK_STATE) ? word_reg : INSTR.bit_byte;
        bit_hit   = bit_src[INSTR.bit_sel];
        bit_mask  = 8'h01 << INSTR.bit_sel;
        dec_val   = 8'h00;
        unique case (INSTR.op)
            OP_POP_STATE: begin
                word_next = INSTR.opnd_lo;
                sp_next  = sp_reg + 16'h0001;
            end
            OP_POP_PAIR: begin
                wb_next.reg_pair = {INSTR.opnd_hi, INSTR.opnd_lo};
                wb_next.pair_wr  = 1'b1;
                sp_next          = sp_reg + 16'h0002;
            end
            OP_XFER_SP_IMM:   sp_next = INSTR.imm16;
            OP_XFER_SP_ACCUM: sp_next = INSTR.accum_pair;
            OP_XFER_ACCUM_SP: begin
                wb_next.accum_pair = sp_reg;
                wb_next.accum_wr   = 1'b1;
            end
            OP_JUMP_ABS:   pc_next = INSTR.imm16;
            OP_JUMP_REL:   pc_next = rel_pc;
            OP_JUMP_ACCUM: pc_next = INSTR.accum_pair;
            OP_CARRY_BRANCH:
                if (word_reg[`SBCX_BIT_CARRY]) pc_next = rel_pc;
            OP_NO_CARRY_BRANCH:
                if (!word_reg[`SBCX_BIT_CARRY]) pc_next = rel_pc;
            OP_NULL_BRANCH:
                if (word_reg[`SBCX_BIT_NULL]) pc_next = rel_pc;
            OP_NONNULL_BRANCH:
                if (!word_reg[`SBCX_BIT_NULL]) pc_next = rel_pc;
            OP_BIT_TRUE_BRANCH:
                if (bit_hit) pc_next = rel_pc;
            OP_BIT_FALSE_BRANCH:
                if (!bit_hit) pc_next = rel_pc;
            OP_BIT_CLEAR_BRANCH:
                if (bit_hit) begin
                    pc_next = rel_pc;
                    // clearing a state-word bit may alter the flags
                    if (INSTR.kind == BK_STATE) begin
                        word_next = word_reg & ~bit_mask;
                    end else begin
                        wb_next.mem_data = INSTR.bit_byte & ~bit_mask;
                        wb_next.mem_wr   = 1'b1;
                    end
                end
            OP_DEC_LOOP_B: begin
                dec_val        = INSTR.b - 8'h01;
                wb_next.b      = dec_val;
                wb_next.b_wr   = 1'b1;
                if (dec_val != 8'h00) pc_next = rel_pc;
            end
            OP_DEC_LOOP_C: begin
                dec_val        = INSTR.c - 8'h01;
                wb_next.c      = dec_val;
                wb_next.c_wr   = 1'b1;
                if (dec_val != 8'h00) pc_next = rel_pc;
            end
            OP_DEC_LOOP_MEM: begin
                dec_val          = INSTR.opnd_lo - 8'h01;
                wb_next.mem_data = dec_val;
                wb_next.mem_wr   = 1'b1;
                if (dec_val != 8'h00) pc_next = rel_pc;
            end
            OP_BANK_SEL: begin
                word_next[`SBCX_BIT_BANK_HIGH] = INSTR.bank[1];
                word_next[`SBCX_BIT_BANK_LOW]  = INSTR.bank[0];
            end
            OP_IDLE_INSTR: word_next = word_reg;
            OP_INT_UNMASK: word_next[`SBCX_BIT_GATE] = 1'b1;
            OP_INT_MASK:   word_next[`SBCX_BIT_GATE] = 1'b0;
            OP_HALT:       halt_next = 1'b1;
            OP_STOP:       stop_next = 1'b1;
            default:       pc_next = pc_reg + {13'h0000, `SBCX_LEN_1};
        endcase
    end

    assign commit = (state_reg == ST_EXEC) && cpu_en_reg &&
                    (cnt_reg == 4'(need_reg - 4'h1));

    // sequencing: results are held until the last cpu cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            need_reg      <= 4'h0;
            cur_reg       <= '0;
            pc_pend_reg   <= `SBCX_PC_RST;
            sp_pend_reg   <= `SBCX_SP_RST;
            word_pend_reg <= `SBCX_STATE_RST;
            wb_pend_reg   <= '0;
            halt_pend_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE:
                    if (START) begin
                        state_reg     <= ST_EXEC;
                        cnt_reg       <= 4'h0;
                        need_reg      <= cyc_of(INSTR);
                        cur_reg       <= INSTR;
                        pc_pend_reg   <= pc_next;
                        sp_pend_reg   <= sp_next;
                        word_pend_reg <= word_next;
                        wb_pend_reg   <= wb_next;
                        halt_pend_reg <= halt_next;
                        stop_pend_reg <= stop_next;
                    end
                ST_EXEC:
                    if (commit) begin
                        state_reg <= stop_pend_reg ? ST_STOP :
                                     halt_pend_reg ? ST_HALT : ST_IDLE;
                    end else if (cpu_en_reg) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                ST_HALT, ST_STOP:
                    if (WAKE) state_reg <= ST_IDLE;
            endcase
        end
    end

    // committed architectural state and status outputs
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pc_reg      <= `SBCX_PC_RST;
            sp_reg      <= `SBCX_SP_RST;
            word_reg    <= `SBCX_STATE_RST;
            wb_reg      <= '0;
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            halted_reg  <= 1'b0;
            stopped_reg <= 1'b0;
        end else begin
            done_reg <= commit;
            // write strobes last a single cycle
            wb_reg   <= commit ? wb_pend_reg : '0;
            if (commit) begin
                pc_reg  <= pc_pend_reg;
                sp_reg  <= sp_pend_reg;
                word_reg <= word_pend_reg;
            end
            busy_reg    <= commit ? (halt_pend_reg || stop_pend_reg) :
                           (state_reg == ST_IDLE) ? START :
                           !((state_reg != ST_EXEC) && WAKE);
            halted_reg  <= commit ? halt_pend_reg :
                           (halted_reg && !WAKE);
            stopped_reg <= commit ? stop_pend_reg :
                           (stopped_reg && !WAKE);
        end
    end

    assign PC                 = pc_reg;
    assign SP                 = sp_reg;
    assign PROGRAM_STATE_WORD = word_reg;
    assign WB                 = wb_reg;
    assign DONE               = done_reg;
    assign BUSY               = busy_reg;
    assign HALTED             = halted_reg;
    assign STOPPED            = stopped_reg;

    // checking helpers, read only by the assertions
    logic [3:0] chk_cnt_reg;
    logic       carry_now, z_now;
    assign carry_now = word_reg[`SBCX_BIT_CARRY];
    assign z_now     = word_reg[`SBCX_BIT_NULL];

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) chk_cnt_reg <= 4'h0;
        else if (state_reg == ST_IDLE && START) chk_cnt_reg <= 4'h0;
        else if (state_reg == ST_EXEC && cpu_en_reg)
            chk_cnt_reg <= chk_cnt_reg + 4'h1;
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    property p_pop_state;
        DONE && cur_reg.op == OP_POP_STATE |->
            word_reg == cur_reg.opnd_lo && sp_reg == $past(sp_reg) + 16'h0001;
    endproperty
    a_pop_state: assert property (p_pop_state)
        else $error("state pop wrong");

    property p_pop_pair;
        DONE && cur_reg.op == OP_POP_PAIR |-> WB.pair_wr &&
            WB.reg_pair == {cur_reg.opnd_hi, cur_reg.opnd_lo} &&
            sp_reg == $past(sp_reg) + 16'h0002 && chk_cnt_reg == 4'h4;
    endproperty
    a_pop_pair: assert property (p_pop_pair)
        else $error("pair pop wrong");

    property p_jump_accum;
        DONE && cur_reg.op == OP_JUMP_ACCUM |->
            pc_reg == cur_reg.accum_pair && chk_cnt_reg == 4'h8;
    endproperty
    a_jump_accum: assert property (p_jump_accum)
        else $error("accum jump wrong");

    property p_carry_branch;
        DONE && cur_reg.op == OP_CARRY_BRANCH |-> pc_reg == ($past(carry_now) ?
            rel_tgt($past(pc_reg), 3'h2, cur_reg.rel_offset) :
            $past(pc_reg) + 16'h0002);
    endproperty
    a_carry_branch: assert property (p_carry_branch)
        else $error("carry branch wrong");

    property p_no_carry_branch;
        DONE && cur_reg.op == OP_NO_CARRY_BRANCH && $past(carry_now) |->
            pc_reg == $past(pc_reg) + 16'h0002;
    endproperty
    a_no_carry_branch: assert property (p_no_carry_branch)
        else $error("no-carry branch taken with carry set");

    property p_null_branch;
        DONE && cur_reg.op == OP_NULL_BRANCH && $past(z_now) |->
            pc_reg == rel_tgt($past(pc_reg), 3'h2, cur_reg.rel_offset);
    endproperty
    a_null_branch: assert property (p_null_branch)
        else $error("null branch not taken");

    property p_nonnull_branch;
        DONE && cur_reg.op == OP_NONNULL_BRANCH && !$past(z_now) |->
            pc_reg == rel_tgt($past(pc_reg), 3'h2, cur_reg.rel_offset)
            && chk_cnt_reg == 4'h6;
    endproperty
    a_nonnull_branch: assert property (p_nonnull_branch)
        else $error("nonnull branch not taken");

    property p_bit_true;
        DONE && cur_reg.op == OP_BIT_TRUE_BRANCH && cur_reg.kind != BK_STATE
            && cur_reg.bit_byte[cur_reg.bit_sel] |->
            pc_reg == rel_tgt($past(pc_reg),
                (cur_reg.kind == BK_SFR) ? 3'h4 : 3'h3, cur_reg.rel_offset);
    endproperty
    a_bit_true: assert property (p_bit_true)
        else $error("bit-true branch target wrong");

    property p_bit_clear;
        DONE && cur_reg.op == OP_BIT_CLEAR_BRANCH && cur_reg.kind != BK_STATE
            && cur_reg.bit_byte[cur_reg.bit_sel] |->
            WB.mem_wr && !WB.mem_data[cur_reg.bit_sel];
    endproperty
    a_bit_clear: assert property (p_bit_clear)
        else $error("tested bit not cleared");

    property p_dec_loop;
        DONE && cur_reg.op == OP_DEC_LOOP_B |->
            WB.b_wr && WB.b == 8'(cur_reg.b - 8'h01);
    endproperty
    a_dec_loop: assert property (p_dec_loop)
        else $error("loop decrement wrong");

    property p_gate;
        DONE && (cur_reg.op == OP_INT_UNMASK || cur_reg.op == OP_INT_MASK)
            |-> word_reg[`SBCX_BIT_GATE] == (cur_reg.op == OP_INT_UNMASK);
    endproperty
    a_gate: assert property (p_gate)
        else $error("interrupt gate flag wrong");

    property p_cycles;
        DONE |-> chk_cnt_reg == cyc_of(cur_reg);
    endproperty
    a_cycles: assert property (p_cycles)
        else $error("cycle count wrong");

    property p_bank;
        DONE && cur_reg.op == OP_BANK_SEL |->
            word_reg[`SBCX_BIT_BANK_HIGH] == cur_reg.bank[1] &&
            word_reg[`SBCX_BIT_BANK_LOW] == cur_reg.bank[0];
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank bits wrong");

    property p_pause;
        DONE && cur_reg.op == OP_STOP |-> (STOPPED && BUSY) [*2];
    endproperty
    a_pause: assert property (p_pause)
        else $error("stop mode not entered");

endmodule : sbcx_core
`default_nettype wire

/* dv/sbcx_core_tb_top.sv */
// self-checking bench for the stack, branch and control unit
`default_nettype none
module sbcx_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sbcx_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  clk_sel = 3'h0;
    logic        start = 1'b0;
    logic        wake = 1'b0;
    sbcx_instr_t ins = '0;
    logic [15:0] pc, sp, m_pc = 16'h0000, m_sp = 16'h0000;
    logic [7:0]  st_word, m_word = 8'h00, v, tb;
    sbcx_wb_t    wb;
    logic        done, busy, halted, stopped, t;
    integer      errors = 0, total_checks = 0, seed = 32'h4F22, r, k, n, kd;

    sbcx_core sbcx_core_i (.REF_CLK(ref_clk), .NRST(nrst), .CLK_SEL(clk_sel),
        .START(start), .INSTR(ins), .WAKE(wake), .PC(pc), .SP(sp),
        .PROGRAM_STATE_WORD(st_word), .WB(wb), .DONE(done), .BUSY(busy),
        .HALTED(halted), .STOPPED(stopped));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    function automatic logic [15:0] sx(input logic [7:0] o);
        return {{8{o[7]}}, o};
    endfunction : sx

    // start one instruction and wait for its commit, counting edges
    task automatic go(input sbcx_op_t op, input int cyc);
        int c, m;
        c = 0;
        m = 1 << clk_sel;
        ins.op = op;
        start = 1'b1;
        @(posedge ref_clk);
        #1 start = 1'b0;
        check("busy", busy, 1'b1);
        // first counted pulse lands 1 to m edges after the start edge
        while (done !== 1'b1 && c < 400) begin
            @(posedge ref_clk);
            #1 c = c + 1;
        end
        check("cycles", 16'(c > cyc*m - m && c <= cyc*m), 16'h1);
        check("busy_end", busy, op == OP_HALT || op == OP_STOP);
    endtask : go

    task automatic cmp();
        check("pc", pc, m_pc);
        check("sp", sp, m_sp);
        check("word", {8'h00, st_word}, {8'h00, m_word});
    endtask : cmp

    initial begin
        #1_000_000;
        errors = errors + 1;
        close_out();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 nrst = 1'b1;
        cmp();
        check("flags", {done, busy, halted, stopped}, 4'h0);
        r = $random(seed);
        ins.opnd_lo = r[7:0];
        ins.opnd_hi = r[15:8];
        ins.accum_pair = r[31:16];
        go(OP_POP_PAIR, 4);
        m_sp = m_sp + 2;
        m_pc = m_pc + 1;
        check("pair", wb.reg_pair, r[15:0]);
        check("pair_wr", wb.pair_wr, 1'b1);
        m_pc = r[31:16];
        go(OP_JUMP_ACCUM, 8);
        cmp();
        // stack pointer moves and plain jumps
        m_sp = r[31:16];
        m_pc = m_pc + 2;
        go(OP_XFER_SP_ACCUM, 8);
        cmp();
        m_pc = m_pc + 2;
        go(OP_XFER_ACCUM_SP, 8);
        check("accum", wb.accum_pair, m_sp);
        check("accum_wr", wb.accum_wr, 1'b1);
        ins.imm16 = r[15:0];
        m_sp = r[15:0];
        m_pc = m_pc + 4;
        go(OP_XFER_SP_IMM, 10);
        cmp();
        ins.imm16 = ~r[15:0];
        m_pc = ~r[15:0];
        go(OP_JUMP_ABS, 6);
        cmp();
        ins.rel_offset = r[23:16];
        m_pc = m_pc + 2 + sx(r[23:16]);
        go(OP_JUMP_REL, 6);
        cmp();
        // flags come from a popped word, so both senses get exercised
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            ins.opnd_lo = r[7:0];
            ins.rel_offset = r[15:8];
            m_word = r[7:0];
            m_sp = m_sp + 1;
            m_pc = m_pc + 1;
            go(OP_POP_STATE, 2);
            cmp();
            k = i % 4;
            t = (k > 1 ? r[6] : r[0]) ^ k[0];
            m_pc = m_pc + 2 + (t ? sx(r[15:8]) : 16'h0000);
            go(sbcx_op_t'(5'h08 + 5'(k)), 6);
            cmp();
        end
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            k = i % 3;
            // kinds: 0 saddr, 1 sfr, 2 accumulator, 3 state word, 4 hl
            kd = r[26:24] % 5;
            ins.kind = sbcx_bit_kind_t'(kd);
            ins.slow = r[1];
            ins.bit_sel = r[4:2];
            ins.bit_byte = r[15:8];
            ins.rel_offset = r[23:16];
            tb = (kd == 3) ? m_word : r[15:8];
            t = tb[r[4:2]] ^ (k == 1);
            n = kd == 2 ? 8 : (kd == 3 && k == 0) ? 9 : kd % 2 ? 11 + (k == 2)
                : (kd == 0 && k == 0 ? 8 : 10) + (r[1] ? 1 + (k == 2) : 0);
            v = (kd == 2 || kd == 4 || (k == 0 && kd != 1)) ? 8'h03 : 8'h04;
            m_pc = m_pc + v + (t ? sx(r[23:16]) : 16'h0000);
            if (k == 2 && kd == 3 && t) m_word = m_word & ~(8'h01 << r[4:2]);
            go(sbcx_op_t'(5'h0C + 5'(k)), n);
            cmp();
            if (k == 2) begin
                t = t && kd != 3;
                check("clr_wr", wb.mem_wr, t);
                tb = tb & ~(8'h01 << r[4:2]);
                if (t) check("clr_data", wb.mem_data, tb);
            end
        end
        // a count of one must fall through, larger counts loop
        for (int i = 0; i < 9; i++) begin
            r = $random(seed);
            k = i % 3;
            v = (i < 3) ? 8'h01 : r[7:0];
            ins.b = v;
            ins.c = v;
            ins.opnd_lo = v;
            ins.slow = r[8];
            ins.rel_offset = r[23:16];
            v = v - 8'h01;
            m_pc = m_pc + (k == 2 ? 3 : 2) + (v != 0 ? sx(r[23:16]) : 0);
            go(sbcx_op_t'(5'h0F + 5'(k)), k < 2 ? 6 : (r[8] ? 10 : 8));
            cmp();
            tb = k == 2 ? wb.mem_data : (k ? wb.c : wb.b);
            check("loop_val", tb, v);
        end
        for (int i = 0; i < 4; i++) begin
            ins.bank = 2'(i);
            m_word[5] = ins.bank[1];
            m_word[3] = ins.bank[0];
            m_pc = m_pc + 2;
            go(OP_BANK_SEL, 4);
            cmp();
            m_word[7] = !i[0];
            m_pc = m_pc + 2;
            go(i[0] ? OP_INT_MASK : OP_INT_UNMASK, 6);
            cmp();
        end
        for (int i = 0; i < 2; i++) begin
            m_pc = m_pc + 2;
            go(i ? OP_STOP : OP_HALT, 6);
            check("pause", {halted, stopped}, i ? 2'b01 : 2'b10);
            ins.op = OP_IDLE_INSTR;
            start = 1'b1;
            @(posedge ref_clk);
            #1 start = 1'b0;
            cmp();
            wake = 1'b1;
            @(posedge ref_clk);
            #1 wake = 1'b0;
            check("woken", {halted, stopped}, 2'b00);
        end
        // slower cpu clock stretches every counted cycle
        clk_sel = 3'h2;
        m_pc = m_pc + 1;
        go(OP_IDLE_INSTR, 2);
        cmp();
        close_out();
    end
endmodule : sbcx_core_tb_top
`default_nettype wire
